// file: hdl/sudc_map.svh
// Purpose: offsets, fields, reset values and timing counts of the up/down counter
// Assumes: 32-bit apb data, one word per register
// Notes: definitions only
`ifndef SUDC_MAP_SVH
`define SUDC_MAP_SVH
`define SUDC_CTRL_OFS 12'h000
`define SUDC_PRESET_OFS 12'h004
`define SUDC_STATUS_OFS 12'h008
`define SUDC_IRQ_STAT_OFS 12'h00c
`define SUDC_IRQ_MASK_OFS 12'h010
`define SUDC_CTRL_LOAD_N 0
`define SUDC_CTRL_CEP_N 1
`define SUDC_CTRL_CET_N 2
`define SUDC_CTRL_UP 3
`define SUDC_CTRL_RST 4'hf
`define SUDC_IRQ_TC 0
`define SUDC_IRQ_LOAD 1
`define SUDC_IRQ_W 2
`define SUDC_CLK_NS 50
`endif

// file: hdl/sudc_pkg.sv
// Purpose: shared types of the up/down counter
// Assumes: nothing
// Notes: offsets live in sudc_map.svh
package sudc_pkg;
  typedef enum logic [2:0] {
    SUDC_HOLD = 3'b001,
    SUDC_LOAD = 3'b010,
    SUDC_COUNT = 3'b100
  } sudc_mode_e;
  typedef logic [3:0] sudc_cnt_t;
endpackage

// file: hdl/sudc_if.sv
// Purpose: carries control and state between the register slave and the counter core
// Assumes: one clock
// Notes: core drives state, host side drives controls
`timescale 1ns/10ps
interface sudc_if;
  logic load_enable_n;
  logic count_enable_parallel_n;
  logic count_enable_trickle_n;
  logic up;
  logic [3:0] preset_in;
  logic [3:0] count_out;
  logic terminal_count_n;
  modport core (
    input load_enable_n, count_enable_parallel_n, count_enable_trickle_n, up, preset_in,
    output count_out, terminal_count_n
  );
  modport ctl (
    output load_enable_n, count_enable_parallel_n, count_enable_trickle_n, up, preset_in,
    input count_out, terminal_count_n
  );
endinterface

// file: hdl/sudc_core.sv
// Purpose: four-stage synchronous up/down counter, decade or binary
// Assumes: controls sampled on rising pclk
// Notes: terminal count is combinational and may glitch
`timescale 1ns/10ps
module sudc_core #(
  parameter bit DECADE = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // counter side
  sudc_if.core cif
);
  sudc_pkg::sudc_cnt_t cnt;
  sudc_pkg::sudc_cnt_t next_cnt;
  sudc_pkg::sudc_mode_e mode;
  logic [3:0] top;

  assign top = DECADE ? 4'h9 : 4'hf;

  always_comb begin
    if (!cif.load_enable_n) begin
      mode = sudc_pkg::SUDC_LOAD;
    end else if (!cif.count_enable_parallel_n && !cif.count_enable_trickle_n) begin
      mode = sudc_pkg::SUDC_COUNT;
    end else begin
      mode = sudc_pkg::SUDC_HOLD;
    end
  end

  always_comb begin
    next_cnt = cnt;
    unique case (mode)
      sudc_pkg::SUDC_LOAD: next_cnt = cif.preset_in;
      sudc_pkg::SUDC_COUNT: begin
        // illegal decade states go to 0 upward or 9 downward, so one count rejoins
        if (cif.up) begin
          next_cnt = (cnt >= top) ? 4'h0 : cnt + 4'h1;
        end else begin
          next_cnt = (cnt == 4'h0 || cnt > top) ? top : cnt - 4'h1;
        end
      end
      sudc_pkg::SUDC_HOLD: next_cnt = cnt;
    endcase
  end

  // no reset on the device itself; presetn gives a defined start of 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign cif.count_out = cnt;
  assign cif.terminal_count_n = !(!cif.count_enable_trickle_n &&
    (cif.up ? (DECADE ? (cnt[0] && cnt[3]) : (cnt == 4'hf)) : (cnt == 4'h0)));

  a_load_copies: assert property (@(posedge pclk) disable iff (!presetn)
    !cif.load_enable_n |=> cnt == $past(cif.preset_in)) else $error("load did not copy preset");
  a_load_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (!cif.load_enable_n && !cif.count_enable_parallel_n && !cif.count_enable_trickle_n)
    |=> cnt == $past(cif.preset_in)) else $error("load lost to count");
  a_hold_state: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.load_enable_n && (cif.count_enable_parallel_n || cif.count_enable_trickle_n))
    |=> $stable(cnt)) else $error("counter moved while idle");
  a_count_up: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == sudc_pkg::SUDC_COUNT && cif.up && cnt < top) |=> cnt == $past(cnt) + 4'h1)
    else $error("up count wrong");
  a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == sudc_pkg::SUDC_COUNT && !cif.up && cnt != 4'h0 && cnt <= top)
    |=> cnt == $past(cnt) - 4'h1) else $error("down count wrong");
  a_wrap_mod: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == sudc_pkg::SUDC_COUNT && cif.up && cnt == top) |=> cnt == 4'h0)
    else $error("up wrap wrong");
  a_tc_down: assert property (@(posedge pclk) disable iff (!presetn)
    (!cif.up && !cif.count_enable_trickle_n) |-> (cif.terminal_count_n == (cnt != 4'h0)))
    else $error("down terminal count wrong");
  a_tc_up: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.up && !cif.count_enable_trickle_n && cnt == top) |-> !cif.terminal_count_n)
    else $error("up terminal count missing");
  a_tc_rest: assert property (@(posedge pclk) disable iff (!presetn)
    cif.count_enable_trickle_n |-> cif.terminal_count_n) else $error("terminal count without trickle");
  a_rejoin: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == sudc_pkg::SUDC_COUNT && cnt > top) |=> cnt <= top)
    else $error("illegal state not left");
endmodule

// file: hdl/sudc_top.sv
// Purpose: apb slave wrapping the four-stage up/down counter
// Assumes: pclk 20 MHz, presetn asynchronous active low, zero-wait apb
// Notes: lookahead pins kept at top for cascading stages
//
// Notes on behaviour
// - all state changes on rising clock
// - four stages, decade or modulo sixteen
// - load overrides enables and direction
// - load copies preset into state
// - count only with both enables low
// - direction high increments, low decrements
// - terminal count low at zero counting down
// - up terminal at nine or fifteen
// - parallel enable never affects terminal count
// - decade may flag states 11, 13, 15
// - illegal decade state rejoins after one count
// - terminal count combinational, never a clock
// - terminal count feeds next stage trickle
`timescale 1ns/10ps
`include "sudc_map.svh"
module sudc_top #(
  parameter bit DECADE = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cascade
  input wire logic cascade_trickle_n,
  output logic terminal_count_n,
  output logic [3:0] count_out,
  output logic irq
);
  ////////////////////////////////////////////////////////////////
  sudc_if cif ();
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [3:0] preset;
  logic [3:0] next_preset;
  logic [`SUDC_IRQ_W-1:0] istat;
  logic [`SUDC_IRQ_W-1:0] next_istat;
  logic [`SUDC_IRQ_W-1:0] imask;
  logic [`SUDC_IRQ_W-1:0] next_imask;
  logic [31:0] next_prdata;
  logic wr;
  logic rd;
  logic hit;
  logic tc_prev;
  logic [`SUDC_IRQ_W-1:0] ev;

  // inputs assumed stable at the edge, so taken without synchronisers
  assign cif.load_enable_n = ctrl[`SUDC_CTRL_LOAD_N];
  assign cif.count_enable_parallel_n = ctrl[`SUDC_CTRL_CEP_N];
  // a lower stage's terminal count gates this stage alongside software
  assign cif.count_enable_trickle_n = ctrl[`SUDC_CTRL_CET_N] | cascade_trickle_n;
  assign cif.up = ctrl[`SUDC_CTRL_UP];
  assign cif.preset_in = preset;

  sudc_core #(.DECADE(DECADE)) u_core (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  assign count_out = cif.count_out;
  assign terminal_count_n = cif.terminal_count_n;

  ////////////////////////////////////////////////////////////////
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign hit = paddr == `SUDC_CTRL_OFS || paddr == `SUDC_PRESET_OFS || paddr == `SUDC_STATUS_OFS ||
    paddr == `SUDC_IRQ_STAT_OFS || paddr == `SUDC_IRQ_MASK_OFS;
  assign pslverr = psel && penable && !hit;
  // sampled edge of terminal count, so the glitchy decode is never a clock
  assign ev[`SUDC_IRQ_TC] = tc_prev && !cif.terminal_count_n;
  assign ev[`SUDC_IRQ_LOAD] = !cif.load_enable_n;
  assign irq = |(istat & imask);

  always_comb begin
    next_ctrl = ctrl;
    next_preset = preset;
    next_imask = imask;
    next_istat = istat;
    next_prdata = prdata;
    if (wr) begin
      if (paddr == `SUDC_CTRL_OFS) begin
        next_ctrl = pwdata[3:0];
      end
      if (paddr == `SUDC_PRESET_OFS) begin
        next_preset = pwdata[3:0];
      end
      if (paddr == `SUDC_IRQ_MASK_OFS) begin
        next_imask = pwdata[`SUDC_IRQ_W-1:0];
      end
      if (paddr == `SUDC_IRQ_STAT_OFS) begin
        next_istat = istat & ~pwdata[`SUDC_IRQ_W-1:0];
      end
    end
    // set wins over a clear in the same cycle
    next_istat = next_istat | ev;
    if (rd) begin
      unique case (paddr)
        `SUDC_CTRL_OFS: next_prdata = {28'h0, ctrl};
        `SUDC_PRESET_OFS: next_prdata = {28'h0, preset};
        `SUDC_STATUS_OFS: next_prdata = {27'h0, cif.terminal_count_n, cif.count_out};
        `SUDC_IRQ_STAT_OFS: next_prdata = {30'h0, istat};
        `SUDC_IRQ_MASK_OFS: next_prdata = {30'h0, imask};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SUDC_CTRL_RST;
      preset <= 4'h0;
      imask <= 2'h0;
      istat <= 2'h0;
      prdata <= 32'h0;
      tc_prev <= 1'b1;
    end else begin
      ctrl <= next_ctrl;
      preset <= next_preset;
      imask <= next_imask;
      istat <= next_istat;
      prdata <= next_prdata;
      tc_prev <= cif.terminal_count_n;
    end
  end

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (istat[`SUDC_IRQ_TC] && imask[`SUDC_IRQ_TC]) |-> irq) else $error("irq not raised");
  a_tc_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ev[`SUDC_IRQ_TC] |=> istat[`SUDC_IRQ_TC]) else $error("terminal event lost");
endmodule

// file: sim/sudc_lower_stage.sv
// Purpose: lower cascade stage feeding the block's trickle enable
// Assumes: counts up, own trickle enable held low
// Notes: wakes at fifteen so the upper stage sees terminal count while idle
`timescale 1ns/10ps
module sudc_lower_stage (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  // cascade
  output logic terminal_count_n
);
  sudc_pkg::sudc_cnt_t cnt;
  sudc_pkg::sudc_cnt_t next_cnt;
  always_comb begin
    next_cnt = run ? cnt + 4'h1 : cnt;
  end
  // changes only just after an edge, so it is stable around the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'hf;
    end else begin
      cnt <= next_cnt;
    end
  end
  // decoded from state, used as a level only
  assign terminal_count_n = ~(cnt == 4'hf);
endmodule

// file: sim/sudc_top_test.sv
// Purpose: self-checking bench of the apb up/down counter
// Assumes: binary and decade variants side by side on one bus, zero-wait apb
// Notes: random loads and run lengths from a fixed seed, modes taken in turn
`timescale 1ns/10ps
`include "sudc_map.svh"
module sudc_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cascade_trickle_n;
  logic terminal_count_n;
  logic [3:0] count_out;
  logic irq;
  logic dec_tc_n;
  logic [3:0] dec_count;
  logic run = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [3:0] v;
  logic [3:0] md;
  logic [3:0] modes [3] = '{4'h9, 4'h1, 4'hd};
  int k;
  always #25 pclk = ~pclk;
  sudc_top #(.DECADE(1'b0)) sudc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cascade_trickle_n(cascade_trickle_n), .terminal_count_n(terminal_count_n), .count_out(count_out), .irq(irq));
  sudc_lower_stage sudc_lower_stage_inst (.pclk(pclk), .presetn(presetn), .run(run),
    .terminal_count_n(cascade_trickle_n));
  // decade twin shares the bus writes; only its counter pins are watched
  sudc_top #(.DECADE(1'b1)) sudc_top_dec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .cascade_trickle_n(cascade_trickle_n), .terminal_count_n(dec_tc_n), .count_out(dec_count), .irq());
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    // start on a rising edge; also leaves one idle cycle after the last release
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // load, then park in hold with trickle off
  task automatic set_state(input logic [3:0] s);
    apb(1'b1, `SUDC_PRESET_OFS, {28'h0, s});
    apb(1'b1, `SUDC_CTRL_OFS, 32'h00000000);
    repeat (3) @(posedge pclk);
    apb(1'b1, `SUDC_CTRL_OFS, 32'h0000000f);
    @(negedge pclk);
    check(count_out, s);
    check(dec_count, s);
  endtask
  function automatic logic [3:0] after(input logic [3:0] s, input int n, input logic [3:0] m);
    return (m == 4'h9) ? s + n[3:0] : (m == 4'h1) ? s - n[3:0] : s;
  endfunction
  // decade: states above nine go to zero upward and to nine downward
  function automatic logic [3:0] after_dec(input logic [3:0] s, input int n, input logic [3:0] m);
    logic [3:0] q;
    q = s;
    for (int j = 0; j < n; j++) begin
      if (m == 4'h9) begin
        q = (q >= 4'h9) ? 4'h0 : q + 4'h1;
      end else if (m == 4'h1) begin
        q = (q == 4'h0 || q > 4'h9) ? 4'h9 : q - 4'h1;
      end
    end
    return q;
  endfunction
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(76870));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SUDC_CTRL_OFS, 32'h0);
    check(rd, 32'h0000000f);
    apb(1'b0, `SUDC_STATUS_OFS, 32'h0);
    check(rd, 32'h00000010);
    apb(1'b0, 12'h014, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    // load wins while both enables are low; irq path
    set_state(4'ha);
    apb(1'b0, `SUDC_IRQ_STAT_OFS, 32'h0);
    check(rd & 32'h2, 32'h2);
    @(negedge pclk);
    check(irq, 1'b0);
    apb(1'b1, `SUDC_IRQ_MASK_OFS, 32'h2);
    @(negedge pclk);
    check(irq, 1'b1);
    apb(1'b1, `SUDC_IRQ_STAT_OFS, 32'h2);
    @(negedge pclk);
    check(irq, 1'b0);
    // terminal decode at both ends, parallel enable high
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? 4'h0 : (i < 4) ? 4'hf : 4'($urandom_range(14, 1));
      set_state(v);
      apb(1'b1, `SUDC_CTRL_OFS, {28'h0, i[0], 3'b011});
      @(negedge pclk);
      check(terminal_count_n, !((i[0] && v == 4'hf) || (!i[0] && v == 4'h0)));
      check(dec_tc_n, !(i[0] ? (v[0] && v[3]) : (v == 4'h0)));
      check(count_out, v);
    end
    // random runs counting up, counting down and holding, wrap included
    for (int i = 0; i < 12; i++) begin
      v = 4'($urandom);
      md = modes[i % 3];
      k = $urandom_range(20, 0);
      set_state(v);
      apb(1'b1, `SUDC_CTRL_OFS, {28'h0, md});
      repeat (k) @(posedge pclk);
      apb(1'b1, `SUDC_CTRL_OFS, 32'h0000000f);
      @(negedge pclk);
      check(count_out, after(v, k + 3, md));
      check(dec_count, after_dec(v, k + 3, md));
    end
    // cascade: lower stage gives terminal count once per sixteen edges
    set_state(4'he);
    apb(1'b1, `SUDC_CTRL_OFS, 32'h00000009);
    run <= 1'b1;
    repeat (48) @(posedge pclk);
    run <= 1'b0;
    @(negedge pclk);
    check(count_out, 4'h1);
    check(dec_count, 4'h2);
    final_report();
  end
endmodule
